// ---- rtl/mte_pkg.sv ----
// constants for the machine trap entry and exit unit
package mte_pkg;
    localparam int XLEN = 32;
    // register offsets on the plain register port (word index)
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_TVEC = 4'h1;
    localparam logic [3:0] REG_IE = 4'h2;
    localparam logic [3:0] REG_EPC = 4'h3;
    localparam logic [3:0] REG_CAUSE = 4'h4;
    localparam logic [3:0] REG_PENDING = 4'h5;
    localparam logic [3:0] REG_PRIV = 4'h6;
    // status fields
    localparam int ST_GIE = 3;
    localparam int ST_PIE = 7;
    localparam int ST_PP_LO = 11;
    localparam int ST_PP_HI = 12;
    // enable / pending fields
    localparam int IE_SW = 3;
    localparam int IE_TIMER = 7;
    localparam int IE_EXT = 11;
    // cause codes
    localparam logic [9:0] CODE_SW = 10'h003;
    localparam logic [9:0] CODE_TIMER = 10'h007;
    localparam logic [9:0] CODE_EXT = 10'h00b;
    localparam int CAUSE_IRQ = 31;
    // vector modes
    localparam logic [1:0] MODE_DIRECT = 2'h0;
    localparam logic [1:0] MODE_VECTORED = 2'h1;
    // privilege encodings
    localparam logic [1:0] PRIV_USER = 2'h0;
    localparam logic [1:0] PRIV_MACHINE = 2'h3;
    // reset values
    localparam logic [31:0] STATUS_RST = 32'h0000_1800;
    localparam logic [31:0] TVEC_RST = 32'h0000_0000;
    localparam logic [31:0] IE_RST = 32'h0000_0000;
    localparam logic [31:0] PC_RST = 32'h0000_0000;
    // writable masks; reserved bits keep their value
    localparam logic [31:0] STATUS_WMASK = 32'h0000_1888;
    localparam logic [31:0] IE_WMASK = 32'h0000_0888;
endpackage : mte_pkg

// ---- rtl/mte_trap_unit.sv ----
// machine trap entry, vector generation and trap return for one hart
// How it works
// - global enable clear blocks every interrupt
// - enabled pending interrupt preempts running code
// - any trap enters machine mode, clears enable
// - entry copies enable to prior enable first
// - entry records old privilege in prior field
// - entry saves pc, loads vector from base
// - return restores privilege, enable and pc
// - handler re-enables by write or return
// - status enable bit3, prior bit7, privilege 12:11
// - take source only with global and own enable
// - vector register: mode 1:0, base 31:2
// - direct mode jumps to base unchanged
// - vectored interrupt jumps base plus four times code
// - vectored timer interrupt goes to base plus 1c
// - external interrupt uses code 11, base plus 2c
// - enable register: software bit3, timer bit7
// - only software and timer local inputs exist
// - cause top bit marks interrupt, low bits code
// - external interrupt enable at bit 11
// - priority external, then software, then timer
//
// Design decisions made here: the strobed register port and the address map.
module mte_trap_unit
    import mte_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // interrupt request pins, asynchronous to mclk
    input wire logic sw_irq_req,
    input wire logic timer_irq_req,
    input wire logic ext_irq_req,
    // pipeline side
    input wire logic instr_retire,
    input wire logic [31:0] next_pc,
    input wire logic exc_req,
    input wire logic [9:0] exc_code,
    input wire logic trap_return_instr,
    output logic [31:0] pc,
    output logic redirect,
    output logic trap_taken,
    output logic [1:0] priv_mode
);
    import mte_pkg::*;

    logic [2:0] irq_meta_q;
    logic [2:0] irq_sync_q;
    logic [31:0] status_q;
    logic [31:0] tvec_q;
    logic [31:0] ie_q;
    logic [31:0] epc_q;
    logic [31:0] cause_q;
    logic [1:0] priv_q;
    logic [31:0] pc_q;
    logic redirect_q;
    logic trap_q;
    logic [31:0] pending;
    logic irq_take;
    logic [9:0] irq_code;
    logic trap_go;
    logic [9:0] trap_code;
    logic [31:0] vec_addr;
    logic [31:0] status_w;
    logic [1:0] tvec_mode_w;

    // pins cross into mclk through two flops each
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            irq_meta_q <= 3'h0;
            irq_sync_q <= 3'h0;
        end else begin
            irq_meta_q <= {ext_irq_req, timer_irq_req, sw_irq_req};
            irq_sync_q <= irq_meta_q;
        end
    end

    always_comb begin
        pending = 32'h0000_0000;
        pending[IE_SW] = irq_sync_q[0];
        pending[IE_TIMER] = irq_sync_q[1];
        pending[IE_EXT] = irq_sync_q[2];
    end

    // source gated by own enable and global enable
    always_comb begin
        irq_take = 1'b0;
        irq_code = CODE_EXT;
        if (status_q[ST_GIE]) begin
            if (pending[IE_EXT] && ie_q[IE_EXT]) begin
                irq_take = 1'b1;
                irq_code = CODE_EXT;
            end else if (pending[IE_SW] && ie_q[IE_SW]) begin
                irq_take = 1'b1;
                irq_code = CODE_SW;
            end else if (pending[IE_TIMER] && ie_q[IE_TIMER]) begin
                irq_take = 1'b1;
                irq_code = CODE_TIMER;
            end
        end
    end

    // interrupts outrank a synchronous exception in the same cycle
    assign trap_go = irq_take || exc_req;
    assign trap_code = irq_take ? irq_code : exc_code;

    // vector address; low two bits of base are forced zero
    always_comb begin
        if (irq_take && tvec_q[1:0] == MODE_VECTORED) begin
            // code times four
            vec_addr = {tvec_q[31:2], 2'h0} + {20'h0, trap_code, 2'h0};
        end else begin
            vec_addr = {tvec_q[31:2], 2'h0};
        end
    end

    // software write to status keeps reserved bits
    assign status_w = (status_q & ~STATUS_WMASK) |
        (reg_wdata & STATUS_WMASK);

    // reserved mode values keep the old mode
    assign tvec_mode_w = (reg_wdata[1:0] == MODE_DIRECT ||
        reg_wdata[1:0] == MODE_VECTORED) ? reg_wdata[1:0] : tvec_q[1:0];

    // status and privilege; hardware events win over a software write
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            status_q <= STATUS_RST;
            priv_q <= PRIV_MACHINE;
        end else if (trap_go) begin
            status_q[ST_PIE] <= status_q[ST_GIE];
            status_q[ST_GIE] <= 1'b0;
            status_q[ST_PP_HI:ST_PP_LO] <= priv_q;
            priv_q <= PRIV_MACHINE;
        end else if (trap_return_instr) begin
            priv_q <= status_q[ST_PP_HI:ST_PP_LO];
            status_q[ST_GIE] <= status_q[ST_PIE];
            status_q[ST_PIE] <= 1'b1;
            status_q[ST_PP_HI:ST_PP_LO] <= PRIV_USER;
        end else if (reg_wr && reg_addr == REG_STATUS) begin
            status_q <= status_w;
        end
    end

    // vector base and enables, software owned
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            tvec_q <= TVEC_RST;
            ie_q <= IE_RST;
        end else if (reg_wr) begin
            if (reg_addr == REG_TVEC) begin
                tvec_q <= {reg_wdata[31:2], tvec_mode_w};
            end
            if (reg_addr == REG_IE) begin
                // sw bit3, timer bit7, ext bit11
                ie_q <= (ie_q & ~IE_WMASK) | (reg_wdata & IE_WMASK);
            end
        end
    end

    // return pc and cause, trap wins over a software write
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            epc_q <= PC_RST;
            cause_q <= 32'h0000_0000;
        end else if (trap_go) begin
            epc_q <= next_pc;
            cause_q <= {irq_take, 21'h0, trap_code};
        end else if (reg_wr) begin
            if (reg_addr == REG_EPC) begin
                epc_q <= {reg_wdata[31:1], 1'b0};
            end
            if (reg_addr == REG_CAUSE) begin
                cause_q <= reg_wdata;
            end
        end
    end

    // program counter steering
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pc_q <= PC_RST;
            redirect_q <= 1'b0;
            trap_q <= 1'b0;
        end else begin
            redirect_q <= trap_go || trap_return_instr;
            trap_q <= trap_go;
            if (trap_go) begin
                pc_q <= vec_addr;
            end else if (trap_return_instr) begin
                pc_q <= epc_q;
            end else if (instr_retire) begin
                pc_q <= next_pc;
            end
        end
    end

    // read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_STATUS: reg_rdata <= status_q;
                REG_TVEC: reg_rdata <= tvec_q;
                REG_IE: reg_rdata <= ie_q;
                REG_EPC: reg_rdata <= epc_q;
                REG_CAUSE: reg_rdata <= cause_q;
                REG_PENDING: reg_rdata <= pending;
                REG_PRIV: reg_rdata <= {30'h0, priv_q};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    assign pc = pc_q;
    assign redirect = redirect_q;
    assign trap_taken = trap_q;
    assign priv_mode = priv_q;
endmodule : mte_trap_unit

// ---- sim/mte_irq_src.sv ----
// request lines of the core-local and platform interrupt sources
module mte_irq_src (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [2:0] want,
    output logic sw_irq_req,
    output logic timer_irq_req,
    output logic ext_irq_req
);
    // only two local lines; every global source shares the external line
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            {ext_irq_req, timer_irq_req, sw_irq_req} <= 3'h0;
        end else begin
            {ext_irq_req, timer_irq_req, sw_irq_req} <= want;
        end
    end
endmodule : mte_irq_src

// ---- sim/mte_trap_unit_assertions.sv ----
// concurrent checks on the trap unit ports
module mte_trap_unit_chk (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic instr_retire,
    input wire logic exc_req,
    input wire logic trap_return_instr,
    input wire logic [31:0] pc,
    input wire logic redirect,
    input wire logic trap_taken,
    input wire logic [1:0] priv_mode
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    redir_on_trap_a: assert property (trap_taken |-> redirect)
        else $error("trap without redirect");
    no_retake_a: assert property (trap_taken |=> !trap_taken)
        else $error("trap taken twice in a row");
    entry_machine_a: assert property (trap_taken |-> priv_mode == 2'h3)
        else $error("handler not in machine mode");
    exc_entry_a: assert property (exc_req |=> trap_taken)
        else $error("exception not taken");
    ret_redir_a: assert property (trap_return_instr |=> redirect)
        else $error("return without redirect");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
    pc_hold_a: assert property (!redirect && !$past(instr_retire)
        |-> pc == $past(pc))
        else $error("pc moved without cause");
    priv_cause_a: assert property ($changed(priv_mode)
        |-> trap_taken || $past(trap_return_instr))
        else $error("privilege changed without trap or return");
endmodule : mte_trap_unit_chk
bind mte_trap_unit mte_trap_unit_chk mte_trap_unit_chk_inst (.mclk, .sys_rst,
    .reg_rd, .reg_rdata, .instr_retire, .exc_req, .trap_return_instr, .pc,
    .redirect, .trap_taken, .priv_mode);

// ---- sim/tb_machine_trap_entry_exit.sv ----
// self-checking bench for the machine trap unit
module tb_machine_trap_entry_exit;
    timeunit 1ns;
    timeprecision 1ps;
    import mte_pkg::*;
    logic mclk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, instr_retire = 0;
    logic exc_req = 0, trap_return_instr = 0, redirect, trap_taken;
    logic sw_irq_req, timer_irq_req, ext_irq_req;
    logic [2:0] want = 3'h0;
    logic [3:0] reg_addr = 4'h0;
    logic [9:0] exc_code = 10'h0;
    logic [1:0] priv_mode;
    logic [31:0] reg_wdata = 0, reg_rdata, pc, next_pc = 32'h4440;
    logic [9:0] cd [3] = '{10'h00b, 10'h003, 10'h007};
    int pb [3] = '{2, 0, 1};
    int failures = 0, comparisons = 0, i;
    always #5 mclk = ~mclk;
    mte_irq_src mte_irq_src_inst (.mclk, .sys_rst, .want, .sw_irq_req,
        .timer_irq_req, .ext_irq_req);
    mte_trap_unit mte_trap_unit_inst (.mclk, .sys_rst, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .sw_irq_req, .timer_irq_req,
        .ext_irq_req, .instr_retire, .next_pc, .exc_req, .exc_code,
        .trap_return_instr, .pc, .redirect, .trap_taken, .priv_mode);
    task close_out;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out
    task chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("ERROR %0t saw %h expected %h", $time, s, e);
        end
    endtask : chk
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rd
    // bounded wait for a redirect, then check whether it was a trap
    task wt(input logic t);
        int n;
        n = 0;
        while (redirect !== 1'b1 && n < 20) begin
            @(posedge mclk);
            #1 n++;
        end
        if (n == 20) begin
            failures++;
            close_out();
        end else begin
            chk({31'h0, trap_taken}, {31'h0, t});
        end
    endtask : wt
    task ret;
        @(posedge mclk);
        trap_return_instr <= 1'b1;
        @(posedge mclk);
        trap_return_instr <= 1'b0;
        #1 wt(1'b0);
        chk(pc, 32'h4440);
    endtask : ret
    initial begin
        #100us;
        failures++;
        close_out();
    end
    initial begin
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        instr_retire <= 1'b1;
        @(posedge mclk);
        instr_retire <= 1'b0;
        #1 chk(pc, 32'h4440);
        rd(REG_STATUS, 32'h1800);
        rd(4'hf, 32'h0);
        wr(REG_STATUS, 32'hffff_ffff);
        rd(REG_STATUS, 32'h1888);
        wr(REG_IE, 32'hffff_ffff);
        rd(REG_IE, 32'h0888);
        wr(REG_TVEC, 32'h101);
        wr(REG_TVEC, 32'h102);
        rd(REG_TVEC, 32'h101);
        wr(REG_IE, 32'h0);
        want <= 3'h2;
        repeat (6) @(posedge mclk);
        rd(REG_PENDING, 32'h80);
        rd(REG_CAUSE, 32'h0);
        wr(REG_STATUS, 32'h1800);
        wr(REG_IE, 32'h80);
        repeat (6) @(posedge mclk);
        rd(REG_CAUSE, 32'h0);
        wr(REG_STATUS, 32'h1808);
        #1 wt(1'b1);
        chk(pc, 32'h11c);
        want <= 3'h0;
        rd(REG_CAUSE, 32'h8000_0007);
        rd(REG_STATUS, 32'h1880);
        rd(REG_EPC, 32'h4440);
        ret();
        rd(REG_STATUS, 32'h0088);
        wr(REG_IE, 32'h888);
        want <= 3'h7;
        for (i = 0; i < 3; i++) begin
            // let the return's redirect pulse pass first
            @(posedge mclk);
            #1 wt(1'b1);
            chk(pc, 32'h100 + {20'h0, cd[i], 2'h0});
            want[pb[i]] <= 1'b0;
            rd(REG_CAUSE, 32'h8000_0000 | {22'h0, cd[i]});
            ret();
        end
        wr(REG_TVEC, 32'h100);
        @(posedge mclk);
        exc_req <= 1'b1;
        exc_code <= 10'h002;
        @(posedge mclk);
        exc_req <= 1'b0;
        #1 wt(1'b1);
        chk(pc, 32'h100);
        rd(REG_CAUSE, 32'h2);
        ret();
        close_out();
    end
endmodule : tb_machine_trap_entry_exit
